// ---- grf_regs.svh ----
// Constants of the general register file
`ifndef GRF_REGS_SVH
`define GRF_REGS_SVH
`define GRF_DATA_W 32
`define GRF_IDX_W 5
`define GRF_NUM_REGS 32
`define GRF_ZERO_IDX 5'h00
`define GRF_BRK_TEMP_IDX 5'h19
`define GRF_BRK_RET_IDX 5'h1e
`define GRF_RET_ADDR_IDX 5'h1f
`define GRF_ZERO_VAL 32'h00000000
`endif

// ---- grf_pkg.sv ----
// Types of the general register file
`include "grf_regs.svh"
package grf_pkg;
    typedef logic [`GRF_IDX_W-1:0] grf_idx_t;
    typedef logic [`GRF_DATA_W-1:0] grf_word_t;
    typedef struct packed {
        logic en;
        grf_idx_t idx;
        grf_word_t data;
    } grf_wr_t;
    typedef enum logic [1:0] {
        GRF_SRC_NONE = 2'b00,
        GRF_SRC_DATAPATH = 2'b01,
        GRF_SRC_CALL = 2'b10,
        GRF_SRC_DEBUG = 2'b11
    } grf_src_t;
endpackage

// ---- grf_wr_arb.sv ----
// Write port arbiter: picks one write source per cycle
`timescale 1ns/100ps
`default_nettype none
`include "grf_regs.svh"
module grf_wr_arb
    import grf_pkg::*;
(
    input wire grf_wr_t dp_wr,
    input wire logic call_en,
    input wire grf_word_t call_ret_addr,
    input wire grf_wr_t dbg_wr,
    input wire logic debug_mode,
    output var grf_wr_t wr,
    output var grf_src_t src
);
    always_comb
    begin
        wr = '0;
        src = GRF_SRC_NONE;
        if (debug_mode && dbg_wr.en)
        begin
            wr = dbg_wr;
            src = GRF_SRC_DEBUG;
        end
        else if (call_en)
        begin
            wr.en = 1'b1;
            wr.idx = `GRF_RET_ADDR_IDX;
            wr.data = call_ret_addr;
            src = GRF_SRC_CALL;
        end
        else if (dp_wr.en)
        begin
            wr = dp_wr;
            src = GRF_SRC_DATAPATH;
        end
    end
endmodule // grf_wr_arb
`default_nettype wire

// ---- grf_core.sv ----
// General-purpose register file of the soft processor
// Notes on behaviour
// - Thirty-two 32-bit registers, selected by a 5-bit index.
// - Reading index 0 always gives all zeros.
// - Writes to index 0 are dropped.
// - A call writes its return address into index 31 implicitly, except in a cycle where debug mode carries a debug write.
// - A return reads index 31 implicitly as its target address.
// - Indices 25 and 30 are reserved for the debug module.
// - Only in debug mode may debug overwrite indices 25 and 30; in normal mode its writes are dropped.
`timescale 1ns/100ps
`default_nettype none
`include "grf_regs.svh"
module grf_core
    import grf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire grf_idx_t rd_a_idx,
    output var grf_word_t rd_a_data,
    input wire grf_idx_t rd_b_idx,
    output var grf_word_t rd_b_data,
    input wire grf_wr_t dp_wr,
    input wire logic call_en,
    input wire grf_word_t call_ret_addr,
    output var grf_word_t ret_target,
    input wire logic debug_mode,
    input wire grf_wr_t dbg_wr,
    output logic dp_wr_blocked
);
    // ***************************************************
    // Storage and write
    // ***************************************************
    grf_word_t regs_ff [`GRF_NUM_REGS];
    grf_wr_t wr;
    grf_src_t src;

    function automatic grf_word_t rd_word(input grf_idx_t idx,
                                          input grf_word_t val);
        rd_word = (idx == `GRF_ZERO_IDX) ? `GRF_ZERO_VAL : val;
    endfunction

    function automatic logic is_brk_idx(input grf_idx_t idx);
        is_brk_idx = (idx == `GRF_BRK_TEMP_IDX)
                     || (idx == `GRF_BRK_RET_IDX);
    endfunction

    grf_wr_arb u_arb (
        .dp_wr(dp_wr),
        .call_en(call_en),
        .call_ret_addr(call_ret_addr),
        .dbg_wr(dbg_wr),
        .debug_mode(debug_mode),
        .wr(wr),
        .src(src)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `GRF_NUM_REGS; i++)
                regs_ff[i] <= `GRF_ZERO_VAL;
        end
        else if (wr.en && wr.idx != `GRF_ZERO_IDX)
        begin
            regs_ff[wr.idx] <= wr.data;
        end
    end

    // Datapath write lost to a call or debug write
    assign dp_wr_blocked = dp_wr.en && (src != GRF_SRC_DATAPATH);

    // ***************************************************
    // Read ports
    // ***************************************************
    assign rd_a_data = rd_word(rd_a_idx, regs_ff[rd_a_idx]);
    assign rd_b_data = rd_word(rd_b_idx, regs_ff[rd_b_idx]);
    assign ret_target = regs_ff[`GRF_RET_ADDR_IDX];

    // ***************************************************
    // Checks
    // ***************************************************
    property p_zero_read;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |-> (rd_a_idx != `GRF_ZERO_IDX || rd_a_data == '0)
              && (rd_b_idx != `GRF_ZERO_IDX || rd_b_data == '0);
    endproperty
    a_zero_read: assert property (p_zero_read)
        else $error("index 0 read not zero");

    property p_zero_store;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |-> regs_ff[0] == '0;
    endproperty
    a_zero_store: assert property (p_zero_store)
        else $error("index 0 was written");

    property p_call_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (call_en && !(debug_mode && dbg_wr.en))
        |=> ret_target == $past(call_ret_addr);
    endproperty
    a_call_write: assert property (p_call_write)
        else $error("call did not load return address");

    property p_ret_read;
        @(posedge sys_clk) disable iff (!rst_n)
        wr.en && wr.idx == `GRF_RET_ADDR_IDX
        |=> ret_target == $past(wr.data);
    endproperty
    a_ret_read: assert property (p_ret_read)
        else $error("return target mismatch");

    property p_write_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr.en && wr.idx != 5'h00 && !call_en && !debug_mode
         ##0 (rd_a_idx == wr.idx)[*1])
        |=> rd_a_data == $past(wr.data) || $past(rd_a_idx) != rd_a_idx;
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("write not visible next cycle");

    property p_dbg_priority;
        @(posedge sys_clk) disable iff (!rst_n)
        (debug_mode && dbg_wr.en && dbg_wr.idx != 5'h00)
        |=> regs_ff[$past(dbg_wr.idx)] == $past(dbg_wr.data);
    endproperty
    a_dbg_priority: assert property (p_dbg_priority)
        else $error("debug write lost");

    property p_brk_dp;
        @(posedge sys_clk) disable iff (!rst_n)
        (!debug_mode && dp_wr.en && is_brk_idx(dp_wr.idx) && !call_en)
        |=> regs_ff[$past(dp_wr.idx)] == $past(dp_wr.data);
    endproperty
    a_brk_dp: assert property (p_brk_dp)
        else $error("normal store to debug register lost");

    property p_blocked;
        @(posedge sys_clk) disable iff (!rst_n)
        (dp_wr.en && call_en) |-> dp_wr_blocked;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("blocked flag missing");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !wr.en ##1 1'b1 |-> $stable(ret_target);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without write");

    property p_blk_dbg;
        @(posedge sys_clk) disable iff (!rst_n)
        (debug_mode && dbg_wr.en && dp_wr.en)
        |-> dp_wr_blocked;
    endproperty
    a_blk_dbg: assert property (p_blk_dbg)
        else $error("debug write did not block datapath");

    property p_dp_free;
        @(posedge sys_clk) disable iff (!rst_n)
        (dp_wr.en && !call_en && !(debug_mode && dbg_wr.en))
        |-> !dp_wr_blocked;
    endproperty
    a_dp_free: assert property (p_dp_free)
        else $error("datapath write refused without cause");

    property p_dbg_gated;
        @(posedge sys_clk) disable iff (!rst_n)
        (!debug_mode && dbg_wr.en && !call_en && !dp_wr.en)
        |=> regs_ff[$past(dbg_wr.idx)] == $past(regs_ff[dbg_wr.idx]);
    endproperty
    a_dbg_gated: assert property (p_dbg_gated)
        else $error("debug write taken in normal mode");

    property p_call_wins;
        @(posedge sys_clk) disable iff (!rst_n)
        (call_en && dp_wr.en && dp_wr.idx != `GRF_RET_ADDR_IDX
         && !(debug_mode && dbg_wr.en))
        |=> regs_ff[$past(dp_wr.idx)] == $past(regs_ff[dp_wr.idx]);
    endproperty
    a_call_wins: assert property (p_call_wins)
        else $error("datapath write landed beside a call");

    property p_ret_port;
        @(posedge sys_clk) disable iff (!rst_n)
        (rd_a_idx == `GRF_RET_ADDR_IDX)
        |-> rd_a_data == ret_target;
    endproperty
    a_ret_port: assert property (p_ret_port)
        else $error("return target differs from index 31 read");

    property p_write_read_b;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr.en && wr.idx != `GRF_ZERO_IDX && rd_b_idx == wr.idx)
        |=> rd_b_idx != $past(rd_b_idx) || rd_b_data == $past(wr.data);
    endproperty
    a_write_read_b: assert property (p_write_read_b)
        else $error("write not visible on port b next cycle");

    property p_src_en;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |-> wr.en == (src != GRF_SRC_NONE);
    endproperty
    a_src_en: assert property (p_src_en)
        else $error("write enable and source disagree");

    property p_brk_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (debug_mode && dbg_wr.en && is_brk_idx(dbg_wr.idx))
        ##1 (rd_a_idx == $past(dbg_wr.idx))
        |-> rd_a_data == $past(dbg_wr.data);
    endproperty
    a_brk_read: assert property (p_brk_read)
        else $error("debug register read back wrong");

    c_call: cover property (@(posedge sys_clk) disable iff (!rst_n)
        call_en ##1 ret_target != '0);
    c_dbg: cover property (@(posedge sys_clk) disable iff (!rst_n)
        debug_mode && dbg_wr.en && is_brk_idx(dbg_wr.idx));
    c_zero: cover property (@(posedge sys_clk) disable iff (!rst_n)
        dp_wr.en && dp_wr.idx == 5'h00);
    c_blocked: cover property (@(posedge sys_clk) disable iff (!rst_n)
        dp_wr_blocked && call_en);
    c_brk_normal: cover property (@(posedge sys_clk) disable iff (!rst_n)
        !debug_mode && dp_wr.en && is_brk_idx(dp_wr.idx));
endmodule // grf_core
`default_nettype wire

// ---- grf_pipe_model.sv ----
// Pipeline and debug side model presenting writes
`timescale 1ns/100ps
`default_nettype none
module grf_pipe_model
    import grf_pkg::*;
(
    input wire logic sys_clk,
    input wire grf_wr_t q_dp,
    input wire logic q_call,
    input wire grf_word_t q_ra,
    input wire logic q_dm,
    input wire grf_wr_t q_dbg,
    output var grf_wr_t dp_wr = 38'h0,
    output var logic call_en = 1'b0,
    output var grf_word_t call_ret_addr = 32'h0,
    output var logic debug_mode = 1'b0,
    output var grf_wr_t dbg_wr = 38'h0
);
    // Launch each request just after the edge
    always @(posedge sys_clk)
    begin
        dp_wr <= q_dp;
        call_en <= q_call;
        call_ret_addr <= q_ra;
        debug_mode <= q_dm;
        dbg_wr <= q_dbg;
    end
endmodule // grf_pipe_model
`default_nettype wire

// ---- grf_core_tb.sv ----
// Self-checking bench of the general register file
`timescale 1ns/100ps
`default_nettype none
module grf_core_tb
    import grf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    grf_idx_t rd_a_idx = 5'h00;
    grf_idx_t rd_b_idx = 5'h00;
    grf_word_t rd_a_data, rd_b_data, ret_target, call_ret_addr;
    grf_wr_t dp_wr, dbg_wr;
    logic call_en, debug_mode, dp_wr_blocked;
    grf_wr_t q_dp = 38'h0;
    grf_wr_t q_dbg = 38'h0;
    logic q_call = 1'b0;
    logic q_dm = 1'b0;
    grf_word_t q_ra = 32'h0;
    grf_word_t ref_mem [32];
    int error_cnt = 0;
    int n_checks = 0;
`define GRF_CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", nm, e, s); end end
    initial forever #10 sys_clk = ~sys_clk;
    grf_pipe_model pipe (.sys_clk, .q_dp, .q_call, .q_ra, .q_dm,
        .q_dbg, .dp_wr, .call_en, .call_ret_addr, .debug_mode, .dbg_wr);
    grf_core uut (.sys_clk, .rst_n, .rd_a_idx, .rd_a_data, .rd_b_idx,
        .rd_b_data, .dp_wr, .call_en, .call_ret_addr, .ret_target,
        .debug_mode, .dbg_wr, .dp_wr_blocked);
    function automatic logic exp_blk(grf_wr_t d, logic c, m, grf_wr_t g);
        return d.en & (c | (m & g.en));
    endfunction
    // Index 0 always reads as zero
    function automatic grf_word_t exp_rd(grf_idx_t i);
        return (i == 5'h00) ? 32'h0 : ref_mem[i];
    endfunction
    // Present one request; the pipe launches it at the next edge and its write lands one edge later
    task automatic op(grf_wr_t d, logic c, grf_word_t a, logic m,
        grf_wr_t g);
        grf_wr_t w;
        {q_dp, q_call, q_ra, q_dm, q_dbg} = {d, c, a, m, g};
        @(posedge sys_clk);
        #1;
        `GRF_CHK("blocked", exp_blk(d, c, m, g), dp_wr_blocked)
        w = (m & g.en) ? g : (c ? {1'b1, 5'h1f, a} : d);
        if (w.en && w.idx != 5'h00)
            ref_mem[w.idx] = w.data;
    endtask
    task automatic rd(grf_idx_t a, grf_idx_t b);
        {q_dp, q_call, q_dm, q_dbg} = 78'h0;
        @(posedge sys_clk);
        rd_a_idx <= a;
        rd_b_idx <= b;
        #1;
        `GRF_CHK("rd_a", exp_rd(a), rd_a_data)
        `GRF_CHK("rd_b", exp_rd(b), rd_b_data)
        `GRF_CHK("ret_target", ref_mem[31], ret_target)
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        void'($urandom(56));
        foreach (ref_mem[i])
            ref_mem[i] = 32'h0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 32; i++)
            rd(5'(i), 5'(31 - i));
        op({1'b1, 5'h00, 32'hffffffff}, 1'b0, 32'h0, 1'b0, 38'h0);
        op({1'b1, 5'h05, 32'h0000a5a5}, 1'b1, 32'h00001234, 1'b0,
            38'h0);
        op({1'b1, 5'h19, 32'h11111111}, 1'b0, 32'h0, 1'b1,
            {1'b1, 5'h19, 32'h22222222});
        op({1'b1, 5'h1e, 32'h33333333}, 1'b1, 32'h00000040, 1'b1,
            {1'b1, 5'h1e, 32'h44444444});
        op(38'h0, 1'b0, 32'h0, 1'b0, {1'b1, 5'h1e, 32'h55555555});
        rd(5'h00, 5'h19);
        rd(5'h1e, 5'h05);
        repeat (300)
        begin
            op({1'($urandom), 5'($urandom), $urandom()},
                ($urandom % 4) == 0, $urandom(), 1'($urandom),
                {1'($urandom), 5'($urandom), $urandom()});
            if (($urandom % 2) == 0)
                rd(5'($urandom), 5'($urandom));
        end
        for (int i = 0; i < 32; i++)
            rd(5'(i), 5'(31 - i));
        end_sim();
    end
    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule // grf_core_tb
`default_nettype wire
